// ### rtl/gate_cfg.svh
// Register offsets, field positions and reset values of the gate
`ifndef GATE_CFG_SVH
`define GATE_CFG_SVH
`define OFS_CMD      8'h00
`define OFS_OPA      8'h04
`define OFS_OPB      8'h08
`define OFS_RES      8'h0c
`define OFS_STAT     8'h10
`define OFS_CTL0     8'h14
`define OFS_CTL4     8'h18
`define OFS_GBASE    8'h1c
`define OFS_GLIM     8'h20
`define OFS_IBASE    8'h24
`define OFS_ILIM     8'h28
`define OFS_LSEL     8'h2c
`define OFS_TSEL     8'h30
`define OFS_LDESC    8'h34
`define OFS_TDESC    8'h38
`define OFS_RES2     8'h3c
`define CMD_OP_HI    4
`define CMD_OP_LO    0
`define CMD_CPL_HI   9
`define CMD_CPL_LO   8
`define CMD_LONG     12
`define ST_GP        0
`define ST_NM        1
`define ST_UD        2
`define ST_OK        3
`define ST_DONE      4
`define TS_BIT       3
`define TSD_BIT      2
`define PCE_BIT      8
`define MSW_HI       15
`define DSC_LIM_HI   15
`define DSC_ACC_HI   23
`define DSC_ACC_LO   16
`define ACC_P        7
`define ACC_DPL_HI   6
`define ACC_DPL_LO   5
`define ACC_S        4
`define ACC_CODE     3
`define ACC_CONF     2
`define ACC_RW       1
`define RPL_HI       1
`define SEL_IDX_HI   15
`define SEL_IDX_LO   2
`define CR_SLOTS     6
`define CR8_INDEX    4'h8
`define CR8_SLOT     3'h5
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10
`define RST_WORD     32'h0000_0000
`define CPL_KERNEL   2'h0
`endif

// ### rtl/gate_pkg.sv
// Types shared by the system instruction gate
package gate_pkg;
	typedef enum logic [4:0] {
		global_table_load, global_table_store,
		interrupt_table_load, interrupt_table_store,
		local_table_load, local_table_store,
		task_selector_load, task_selector_store,
		status_word_load, status_word_store,
		clear_task_switched_op, selector_privilege_adjust,
		access_rights_load, segment_limit_load,
		read_verify, write_verify,
		perf_counter_read, timestamp_read,
		control_write, control_read, float_op,
		debug_move, cache_invalidate, cache_writeback_invalidate,
		page_invalidate, halt_op, mgmt_return,
		model_reg_read, model_reg_write, lock_prefix
	} sys_op_t;
endpackage

// ### rtl/system_instruction_privilege_gate.sv
// System instruction decode, privilege check and system table state
`include "gate_cfg.svh"

// What this block does
// RL1 - privileged system instructions need privilege zero
// RL2 - unprotected system instructions run at any level
// RL3 - counter reads above level zero follow flags
// RL4 - timestamp disable flag limits timestamp reads
// RL5 - counter enable flag opens counter reads
// RL6 - status word ops touch low sixteen bits
// RL7 - float op with task switched raises fault
// RL8 - clear task switched op clears the flag
// RL9 - table loads and stores move base, limit
// RL10 - local and task loads take selector, descriptor
// RL11 - local and task stores give selector only
// RL12 - control move covers registers 0-4 and 8
// RL13 - privilege adjust raises selector requestor field
// RL14 - privilege adjust unsupported in long mode
// RL15 - access rights load checks, copies rights
// RL16 - limit load checks, copies segment limit
// RL17 - verify ops report access without faulting
// RL18 - blocked privileged op gives protection fault
module system_instruction_privilege_gate
	import gate_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             protection_fault,
	output logic             device_not_available_fault,
	output logic             unsupported_fault
);

	logic [7:0]  aw_addr;
	logic        aw_full;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        w_full;
	logic        wr_go;
	logic        wr_hit;
	logic        exec;
	logic [31:0] opa;
	logic [31:0] opb;
	logic [31:0] result;
	logic [31:0] result2;
	logic [4:0]  status;
	logic [31:0] ctrl_regs [0:`CR_SLOTS-1];
	logic [31:0] gt_base;
	logic [31:0] gt_limit;
	logic [31:0] it_base;
	logic [31:0] it_limit;
	logic [31:0] lt_sel;
	logic [31:0] lt_desc;
	logic [31:0] ts_sel;
	logic [31:0] ts_desc;
	logic [31:0] tsc_count;
	logic [31:0] op_count;
	sys_op_t     op;
	logic        op_bad;
	logic [1:0]  current_privilege;
	logic        long_mode;
	logic        kernel;
	logic        cr_ok;
	logic [2:0]  cr_slot;
	logic        seg_ok;
	logic        rd_ok;
	logic        wr_ok;
	logic        gp;
	logic        nm;
	logic        ud;
	logic        run;
	logic        next_ok;
	logic        next_res_en;
	logic [31:0] next_res;
	logic [31:0] next_res2;

	////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [31:0] strobe(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [1:0] dpl_of(input logic [31:0] d);
		return d[`DSC_ACC_LO+`ACC_DPL_HI:`DSC_ACC_LO+`ACC_DPL_LO];
	endfunction

	function automatic logic acc_bit(input logic [31:0] d,
		input int b);
		return d[`DSC_ACC_LO+b];
	endfunction

	////////////////////////////////////////////////////////////////////
	// Bus write channel: address and data taken in either order

	assign awready = !aw_full;
	assign wready  = !w_full;
	assign wr_go   = aw_full && w_full && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			aw_addr <= 8'h00;
		end else if (awvalid && awready) begin
			aw_full <= 1'b1;
			aw_addr <= awaddr;
		end else if (wr_go) begin
			aw_full <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full <= 1'b0;
			w_data <= `RST_WORD;
			w_strb <= 4'h0;
		end else if (wvalid && wready) begin
			w_full <= 1'b1;
			w_data <= wdata;
			w_strb <= wstrb;
		end else if (wr_go) begin
			w_full <= 1'b0;
		end
	end

	// Only command and operand words are writable; the rest is state
	assign wr_hit = aw_addr == `OFS_CMD || aw_addr == `OFS_OPA ||
		aw_addr == `OFS_OPB;
	assign exec = wr_go && aw_addr == `OFS_CMD;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			opa <= `RST_WORD;
			opb <= `RST_WORD;
		end else if (wr_go && aw_addr == `OFS_OPA) begin
			opa <= strobe(opa, w_data, w_strb);
		end else if (wr_go && aw_addr == `OFS_OPB) begin
			opb <= strobe(opb, w_data, w_strb);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Decode and privilege check

	always_comb begin
		op        = sys_op_t'(w_data[`CMD_OP_HI:`CMD_OP_LO]);
		op_bad    = w_data[`CMD_OP_HI:`CMD_OP_LO] > 5'(lock_prefix);
		current_privilege       = w_data[`CMD_CPL_HI:`CMD_CPL_LO];
		long_mode = w_data[`CMD_LONG];
		kernel    = current_privilege == `CPL_KERNEL;
		cr_ok     = 1'b1;
		cr_slot   = opb[2:0];
		if (opb[3:0] == `CR8_INDEX) begin
			cr_slot = `CR8_SLOT;
		end else if (opb[3:0] > 4'h4) begin
			cr_ok = 1'b0;
		end
	end

	always_comb begin
		gp = 1'b0;
		case (op)
			// RL1 - privilege zero only
			global_table_load, interrupt_table_load, local_table_load,
			task_selector_load, status_word_load,
			clear_task_switched_op, control_write, control_read,
			debug_move, cache_invalidate, cache_writeback_invalidate,
			page_invalidate, halt_op, mgmt_return, model_reg_read,
			model_reg_write: gp = !kernel;
			// RL3 - flags decide counter reads
			// RL5 - counter enable opens it
			perf_counter_read: gp = !kernel &&
				!ctrl_regs[4][`PCE_BIT];
			// RL4 - timestamp disable restricts it
			timestamp_read: gp = !kernel && ctrl_regs[4][`TSD_BIT];
			// RL2 - unprotected at every level
			default: gp = 1'b0;
		endcase
		// RL7 - float op while task switched
		nm = op == float_op && ctrl_regs[0][`TS_BIT];
		// RL14 - adjust unsupported in long mode
		ud = op_bad || (op == selector_privilege_adjust && long_mode) ||
			((op == control_write || op == control_read) && !cr_ok);
		// RL18 - suppress effect on fault
		run = exec && !gp && !nm && !ud;
	end

	////////////////////////////////////////////////////////////////////
	// Segment checks for the verify family

	always_comb begin
		// RL15 - present, non-null, privilege fits
		seg_ok = acc_bit(opb, `ACC_P) &&
			opa[`SEL_IDX_HI:`SEL_IDX_LO] != 14'h0000 &&
			((acc_bit(opb, `ACC_S) && acc_bit(opb, `ACC_CODE) &&
			acc_bit(opb, `ACC_CONF)) ||
			(current_privilege <= dpl_of(opb) && opa[`RPL_HI:0] <= dpl_of(opb)));
		// RL17 - readable or writable at this level
		rd_ok = seg_ok && acc_bit(opb, `ACC_S) &&
			(!acc_bit(opb, `ACC_CODE) || acc_bit(opb, `ACC_RW));
		wr_ok = seg_ok && acc_bit(opb, `ACC_S) &&
			!acc_bit(opb, `ACC_CODE) && acc_bit(opb, `ACC_RW);
	end

	////////////////////////////////////////////////////////////////////
	// Results that go back to the general registers or memory

	always_comb begin
		next_res_en = 1'b1;
		next_res    = result;
		next_res2   = result2;
		next_ok     = 1'b0;
		case (op)
			// RL9 - base and limit written back
			global_table_store: begin
				next_res  = gt_base;
				next_res2 = gt_limit;
			end
			interrupt_table_store: begin
				next_res  = it_base;
				next_res2 = it_limit;
			end
			// RL11 - selector only, no descriptor
			local_table_store: next_res = lt_sel;
			task_selector_store: next_res = ts_sel;
			// RL6 - low half of main control
			status_word_store: next_res =
				{16'h0000, ctrl_regs[0][`MSW_HI:0]};
			// RL13 - raise requestor field
			selector_privilege_adjust: begin
				next_ok  = opa[`RPL_HI:0] < opb[`RPL_HI:0];
				next_res = next_ok ?
					{opa[31:`RPL_HI+1], opb[`RPL_HI:0]} : opa;
			end
			access_rights_load: begin
				next_ok  = seg_ok;
				next_res = {16'h0000,
					opb[`DSC_ACC_HI:`DSC_ACC_LO], 8'h00};
			end
			// RL16 - limit copied on success
			segment_limit_load: begin
				next_ok  = seg_ok;
				next_res = {16'h0000, opb[`DSC_LIM_HI:0]};
			end
			read_verify: next_ok = rd_ok;
			write_verify: next_ok = wr_ok;
			perf_counter_read: next_res = op_count;
			timestamp_read: next_res = tsc_count;
			// RL12 - control register to general
			control_read: next_res = ctrl_regs[cr_slot];
			default: next_res_en = 1'b0;
		endcase
		// Rights and limit loads into a general register happen only on success
		if ((op == access_rights_load || op == segment_limit_load) &&
			!seg_ok) begin
			next_res_en = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result  <= `RST_WORD;
			result2 <= `RST_WORD;
		end else if (run && next_res_en) begin
			result  <= next_res;
			result2 <= next_res2;
		end
	end

	// Each command replaces the whole status word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= 5'h00;
		end else if (exec) begin
			status[`ST_GP]   <= gp;
			status[`ST_NM]   <= nm;
			status[`ST_UD]   <= ud;
			status[`ST_OK]   <= run && next_ok;
			status[`ST_DONE] <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			protection_fault           <= 1'b0;
			device_not_available_fault <= 1'b0;
			unsupported_fault          <= 1'b0;
		end else begin
			// RL18 - fault pulse instead of effect
			protection_fault           <= exec && gp;
			// RL7 - not-available fault pulse
			device_not_available_fault <= exec && nm;
			unsupported_fault          <= exec && ud;
		end
	end

	////////////////////////////////////////////////////////////////////
	// System table registers

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gt_base  <= `RST_WORD;
			gt_limit <= `RST_WORD;
			it_base  <= `RST_WORD;
			it_limit <= `RST_WORD;
			lt_sel   <= `RST_WORD;
			lt_desc  <= `RST_WORD;
			ts_sel   <= `RST_WORD;
			ts_desc  <= `RST_WORD;
		end else if (run) begin
			// RL9 - base and limit fetched
			if (op == global_table_load) begin
				gt_base  <= opa;
				gt_limit <= opb;
			end
			if (op == interrupt_table_load) begin
				it_base  <= opa;
				it_limit <= opb;
			end
			// RL10 - selector and descriptor both
			if (op == local_table_load) begin
				lt_sel  <= opa;
				lt_desc <= opb;
			end
			if (op == task_selector_load) begin
				ts_sel  <= opa;
				ts_desc <= opb;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `CR_SLOTS; i++) begin
				ctrl_regs[i] <= `RST_WORD;
			end
		end else if (run) begin
			// RL12 - general register to control
			if (op == control_write) begin
				ctrl_regs[cr_slot] <= opa;
			end
			// RL6 - upper half untouched
			if (op == status_word_load) begin
				ctrl_regs[0][`MSW_HI:0] <= opa[`MSW_HI:0];
			end
			// RL8 - clear task switched
			if (op == clear_task_switched_op) begin
				ctrl_regs[0][`TS_BIT] <= 1'b0;
			end
		end
	end

	// Both counters are 32 bits here and simply wrap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tsc_count <= `RST_WORD;
			op_count  <= `RST_WORD;
		end else begin
			tsc_count <= tsc_count + 32'h1;
			if (run) begin
				op_count <= op_count + 32'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus read channel

	assign arready = !rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= `RST_WORD;
			rresp  <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= `RESP_OKAY;
			if (araddr == `OFS_CMD) begin
				rdata <= w_data;
			end else if (araddr == `OFS_OPA) begin
				rdata <= opa;
			end else if (araddr == `OFS_OPB) begin
				rdata <= opb;
			end else if (araddr == `OFS_RES) begin
				rdata <= result;
			end else if (araddr == `OFS_STAT) begin
				rdata <= {27'h0, status};
			end else if (araddr == `OFS_CTL0) begin
				rdata <= ctrl_regs[0];
			end else if (araddr == `OFS_CTL4) begin
				rdata <= ctrl_regs[4];
			end else if (araddr == `OFS_GBASE) begin
				rdata <= gt_base;
			end else if (araddr == `OFS_GLIM) begin
				rdata <= gt_limit;
			end else if (araddr == `OFS_IBASE) begin
				rdata <= it_base;
			end else if (araddr == `OFS_ILIM) begin
				rdata <= it_limit;
			end else if (araddr == `OFS_LSEL) begin
				rdata <= lt_sel;
			end else if (araddr == `OFS_TSEL) begin
				rdata <= ts_sel;
			end else if (araddr == `OFS_LDESC) begin
				rdata <= lt_desc;
			end else if (araddr == `OFS_TDESC) begin
				rdata <= ts_desc;
			end else if (araddr == `OFS_RES2) begin
				rdata <= result2;
			end else begin
				rdata <= `RST_WORD;
				rresp <= `RESP_SLVERR;
			end
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

endmodule

// ### tb/gate_props.sv
// Port checker for the system instruction gate
`include "gate_cfg.svh"
module gate_props
	import gate_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0]  wstrb,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [7:0]  araddr,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic        protection_fault,
	input wire logic        device_not_available_fault,
	input wire logic        unsupported_fault
);
timeunit 1ns;
timeprecision 100ps;
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////
// Last address and word taken, so a response can be tied to its command
logic [7:0]  cmd_addr;
logic [31:0] cmd_word;
logic [4:0]  op;
logic        user;
always_ff @(posedge aclk) begin
	if (awvalid && awready)
		cmd_addr <= awaddr;
end
always_ff @(posedge aclk) begin
	if (wvalid && wready)
		cmd_word <= wdata;
end
assign op = cmd_word[4:0];
assign user = cmd_word[9:8] != `CPL_KERNEL;
sequence cmd_end;
	$rose(bvalid) && cmd_addr == `OFS_CMD;
endsequence
////////////////////////////////////////////////////////////////////////////
priv_blocked_a: assert property (cmd_end ##0 (user && op inside
	{0, 2, 4, 6, 8, 10, 18, 19, [21:28]}) |-> protection_fault)
	else $error("privileged op ran above level zero");
open_ops_a: assert property (cmd_end ##0 (op inside
	{1, 3, 5, 7, 9, 11, 12, 13, 14, 15, 29}) |-> !protection_fault)
	else $error("unprotected op faulted");
kernel_counter_a: assert property (cmd_end ##0 (!user && op inside {16, 17})
	|-> !protection_fault) else $error("kernel counter read faulted");
long_adjust_a: assert property (cmd_end ##0 (op == 5'd11
	&& cmd_word[`CMD_LONG]) |-> unsupported_fault && !protection_fault)
	else $error("adjust in long mode not refused");
bad_opcode_a: assert property (cmd_end ##0 op > 5'd29 |-> unsupported_fault)
	else $error("unknown opcode not refused");
fault_cause_a: assert property ((protection_fault || unsupported_fault
	|| device_not_available_fault) |-> $rose(bvalid) && cmd_addr == `OFS_CMD)
	else $error("fault pulse without a command");
write_resp_a: assert property ($rose(bvalid) |-> bresp ==
	(cmd_addr > `OFS_OPB ? `RESP_SLVERR : `RESP_OKAY))
	else $error("wrong write response");
read_latency_a: assert property (arvalid && arready |=> rvalid)
	else $error("read answer late");
read_hold_a: assert property (rvalid && !rready |=> rvalid
	&& $stable(rdata) && $stable(rresp)) else $error("read answer dropped");
endmodule

// ### tb/system_instruction_privilege_gate_bench.sv
// Self-checking bench for the system instruction gate
`include "gate_cfg.svh"
module system_instruction_privilege_gate_bench
	import gate_pkg::*;
;
timeunit 1ns;
timeprecision 100ps;
logic             aclk = 1'b0;
logic             aresetn = 1'b0;
logic [7:0]       awaddr = 8'h00;
logic [7:0]       araddr = 8'h00;
logic [31:0]      wdata = 32'h0;
logic [3:0]       wstrb = 4'h0;
logic             awvalid = 1'b0;
logic             wvalid = 1'b0;
logic             bready = 1'b0;
logic             arvalid = 1'b0;
logic             rready = 1'b0;
wire logic        awready, wready, bvalid, arready, rvalid;
wire logic [1:0]  bresp, rresp;
wire logic [31:0] rdata;
wire logic        protection_fault, device_not_available_fault;
wire logic        unsupported_fault;
int               n_fail = 0;
int               check_count = 0;
// Commands that ran, as the counter read should report them
int               runs = 0;
// Reference copies of the two control words
logic [31:0]      ctl0 = 32'h0;
logic [31:0]      ctl4 = 32'h0;

system_instruction_privilege_gate u_system_instruction_privilege_gate (.*);
always #5 aclk = ~aclk;
////////////////////////////////////////////////////////////////////////////
task automatic results();
	$display("checks %0d mismatches %0d", check_count, n_fail);
	if (n_fail == 0 && check_count > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask
task automatic hang();
	n_fail++;
	$display("unexpected %0t no answer", $time);
	results();
endtask
task automatic chk_word(input logic [31:0] got, input logic [31:0] want,
		input string what);
	check_count++;
	if (got !== want) begin
		n_fail++;
		$display("unexpected %0t %s %h want %h", $time, what, got, want);
	end
endtask
task automatic chk_fault(input logic [2:0] got, input logic [2:0] want,
		input int op);
	check_count++;
	if (got !== want) begin
		n_fail++;
		$display("unexpected %0t op %0d faults %b want %b", $time, op, got, want);
	end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r, output logic [2:0] f);
	logic aw_t, w_t, b_t;
	b_t = 1'b0;
	@(posedge aclk);
	awaddr <= a;
	wdata <= d;
	wstrb <= 4'hf;
	awvalid <= 1'b1;
	wvalid <= 1'b1;
	bready <= 1'b1;
	for (int n = 0; n < 50 && !b_t; n++) begin
		@(negedge aclk);
		aw_t = awvalid && awready;
		w_t = wvalid && wready;
		b_t = bvalid;
		r = bresp;
		f = {protection_fault, device_not_available_fault, unsupported_fault};
		@(posedge aclk);
		if (aw_t)
			awvalid <= 1'b0;
		if (w_t)
			wvalid <= 1'b0;
		if (b_t)
			bready <= 1'b0;
	end
	if (!b_t)
		hang();
endtask
task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
	logic tk, fin;
	fin = 1'b0;
	@(posedge aclk);
	araddr <= a;
	arvalid <= 1'b1;
	rready <= 1'b1;
	for (int n = 0; n < 50 && !fin; n++) begin
		@(negedge aclk);
		tk = arvalid && arready;
		fin = rvalid && rready;
		d = rdata;
		r = rresp;
		@(posedge aclk);
		if (tk)
			arvalid <= 1'b0;
		if (fin)
			rready <= 1'b0;
	end
	if (!fin)
		hang();
endtask
function automatic logic [2:0] exp_fault(int op, int current_privilege, logic lng, int b);
	logic gp, ud;
	gp = current_privilege != 0 && (op inside {0, 2, 4, 6, 8, 10, 18, 19}
		|| (op > 20 && op < 29));
	if (op == 16)
		gp = current_privilege != 0 && !ctl4[8];
	if (op == 17)
		gp = current_privilege != 0 && ctl4[2];
	ud = op > 29 || (op == 11 && lng)
		|| (op inside {18, 19} && !(b inside {0, 1, 2, 3, 4, 8}));
	return {gp, op == 20 && ctl0[3], ud};
endfunction
task automatic cmd(input int op, input int current_privilege, input logic lng,
		input logic [31:0] a, input logic [31:0] b);
	logic [1:0] r;
	logic [2:0] f, want;
	logic [31:0] d;
	want = exp_fault(op, current_privilege, lng, b);
	wr(`OFS_OPA, a, r, f);
	wr(`OFS_OPB, b, r, f);
	wr(`OFS_CMD, {19'h0, lng, 2'h0, 2'(current_privilege), 3'h0, 5'(op)}, r, f);
	chk_fault(f, want, op);
	if (want == 3'b000) begin
		if (op == 16) begin
			rd(`OFS_RES, d, r);
			chk_word(d, 32'(runs), "counter read");
		end
		runs++;
		if (op == 18 && b == 0)
			ctl0 = a;
		if (op == 18 && b == 4)
			ctl4 = a;
		if (op == 8)
			ctl0[15:0] = a[15:0];
		if (op == 10)
			ctl0[3] = 1'b0;
	end
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
	logic [31:0] d, a, e;
	logic [1:0] r;
	logic [2:0] f;
	logic [7:0] p;
	void'($urandom(6956));
	repeat (6) @(posedge aclk);
	aresetn <= 1'b1;
	for (int i = 0; i < 10; i++) begin
		rd(8'h14 + 8'(4 * i), d, r);
		chk_word(d, 32'h0, "reset value");
	end
	rd(8'h40, d, r);
	chk_word(32'(r), 32'(`RESP_SLVERR), "unmapped read");
	wr(`OFS_RES, 32'h1, r, f);
	chk_word(32'(r), 32'(`RESP_SLVERR), "read-only write");
	$display("test bus done");
	for (int op = 0; op < 32; op++)
		for (int k = 0; k < 2; k++)
			cmd(op, k ? 1 + $urandom % 3 : 0, 1'($urandom), $urandom, 0);
	$display("test privilege table done");
	cmd(18, 0, 1'b0, 32'hffff_0008, 0);
	cmd(20, 3, 1'b0, 0, 0);
	cmd(10, 3, 1'b0, 0, 0);
	cmd(8, 0, 1'b0, 32'hbeef_123c, 0);
	rd(`OFS_CTL0, d, r);
	chk_word(d, 32'hffff_123c, "status load");
	cmd(9, 3, 1'b0, 0, 0);
	rd(`OFS_RES, d, r);
	chk_word(d, 32'h0000_123c, "status store");
	cmd(20, 1, 1'b0, 0, 0);
	cmd(10, 0, 1'b0, 0, 0);
	cmd(20, 2, 1'b0, 0, 0);
	rd(`OFS_CTL0, d, r);
	chk_word(d, ctl0, "flag cleared");
	$display("test task switched done");
	for (int m = 0; m < 4; m++) begin
		cmd(18, 0, 1'b0, {23'h0, 1'(m / 2), 5'h0, 1'(m % 2), 2'h0}, 4);
		rd(`OFS_CTL4, d, r);
		chk_word(d, ctl4, "control four");
		for (int c = 0; c < 4; c++) begin
			cmd(16, c, 1'b0, 0, 0);
			cmd(17, c, 1'b0, 0, 0);
		end
	end
	cmd(18, 0, 1'b0, 1, 5);
	cmd(19, 0, 1'b0, 0, 8);
	$display("test counters done");
	for (int t = 0; t < 4; t++) begin
		a = t < 2 ? $urandom : $urandom % 65536;
		e = $urandom % 65536;
		p = t < 2 ? 8'h1c + 8'(8 * t) : 8'h2c + 8'(4 * t - 8);
		cmd(2 * t, 0, 1'b0, a, e);
		rd(p, d, r);
		chk_word(d, a, "table base");
		rd(t < 2 ? p + 8'h4 : p + 8'h8, d, r);
		chk_word(d, e, "table limit");
		cmd(2 * t + 1, 2, 1'b0, 0, 0);
		rd(`OFS_RES, d, r);
		chk_word(d, a, "stored value");
		if (t < 2) begin
			rd(`OFS_RES2, d, r);
			chk_word(d, e, "stored limit");
		end
	end
	$display("test tables done");
	for (int i = 0; i < 16; i++) begin
		a = ($urandom % 16384) * 4 + i % 4;
		e = i % 4 < i / 4 ? {a[31:2], 2'(i / 4)} : a;
		cmd(11, $urandom % 4, 1'b0, a, 32'(i / 4));
		rd(`OFS_RES, d, r);
		chk_word(d, e, "adjusted selector");
		rd(`OFS_STAT, d, r);
		chk_word(32'(d[3]), 32'(i % 4 < i / 4), "adjust flag");
	end
	cmd(11, 0, 1'b1, 0, 0);
	$display("test adjust done");
	for (int i = 0; i < 4; i++) begin
		for (int op = 12; op < 16; op++) begin
			p = i == 1 ? 8'h72 : (i == 2 ? 8'h92 : 8'hf2);
			a = i == 3 ? 32'h3 : 32'hb;
			cmd(op, 3, 1'b0, a, {8'h0, p, 16'h0abc});
			rd(`OFS_STAT, d, r);
			chk_word(32'(d[3]), 32'(i == 0), "access flag");
			if (i == 0 && op < 14) begin
				e = op == 12 ? {16'h0, p, 8'h0} : 32'h0abc;
				rd(`OFS_RES, d, r);
				chk_word(d, e, "access result");
			end
		end
	end
	$display("test access checks done");
	results();
end
endmodule

bind system_instruction_privilege_gate gate_props u_gate_props (.*);
